// [src/eeprom_pkg.sv]
// Shared constants and types for the two-wire EEPROM slave.
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int WRITE_TIME_MS = 5;
  // Longest programming time rounds down to whole cycles.
  localparam int WRITE_CYCLES = WRITE_TIME_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Array and page geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int PAGE_AW = 4;
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_BLK_BIT = 8;

  // ----------------------------------------------------------------
  // Control byte layout
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam int CODE_HI = 7;
  localparam int CODE_LO = 4;
  localparam int CTRL_BLK_BIT = 1;
  localparam int CTRL_RW_BIT = 0;
  localparam logic CTRL_READ = 1'b1;

  // ----------------------------------------------------------------
  // Bit framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_NONE = 4'h0;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] IDX_LAST = 4'hf;

  typedef enum logic [2:0] {
    LINK_CTRL,
    LINK_ADDR,
    LINK_DATA,
    LINK_READ,
    LINK_IGNORE
  } link_phase_t;

  typedef enum logic [1:0] {
    PROG_IDLE,
    PROG_COPY,
    PROG_WAIT
  } prog_state_t;

endpackage

// [src/page_store.sv]
// Byte array of the EEPROM with one write port and one asynchronous read port.
`timescale 1ns/1ps
`default_nettype none
module page_store #(
  parameter int AW = eeprom_pkg::ADDR_W,
  parameter int DW = eeprom_pkg::DATA_W
) (
  input wire logic clk_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);
  import eeprom_pkg::*;

  logic [DW-1:0] cells [2**AW];

  // Cells are only written by the programming sequencer.
  always_ff @(posedge clk_in) begin
    if (ce_in && wr_en_in) begin
      cells[wr_addr_in] <= wr_data_in;
    end
  end

  // The read side runs on the link clock; the array is quiet while it is read,
  // because no frame is acknowledged during programming.
  assign rd_data_out = cells[rd_addr_in];

endmodule
`default_nettype wire

// [src/i2c_eeprom_slave.sv]
// Two-wire serial slave of a 512-byte EEPROM with page writes and half-array protect.
//
// Operation
// (R01) Data changes only while clock low.
// (R02) Protect low: whole array writable.
// (R03) Protect high: upper half never programmed.
// (R04) Master drives clock; device is slave.
// (R05) Transfers begin only from idle bus.
// (R06) Data fall, clock high: start.
// (R07) Data rise, clock high: stop.
// (R08) One bit per clock, sampled high.
// (R09) Receiver pulls data low on ack.
// (R10) No acknowledge while programming runs.
// (R11) Master nack ends read; release data.
// (R12) Control byte: code 1010, block bit.
// (R13) Lowest control bit: one read, zero write.
// (R14) Acknowledge only matching control byte.
// (R15) Write: next byte loads address pointer.
// (R16) Stop after write starts programming.
// (R17) Buffer up to sixteen bytes, commit at stop.
// (R18) Only low four pointer bits increment; reads advance all nine pointer bits.
// (R19) Master keeps page writes in page.
// (R20) Acknowledge polling during programming.
// (R21) Protected write: handshake, no programming.
// (R22) Pointer advances after each byte.
// (R23) Master ack in read: send next byte.
// (R24) Programming finishes within five milliseconds.
`timescale 1ns/1ps
`default_nettype none
module i2c_eeprom_slave #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic wp_in,
  output logic sda_out_out,
  output logic sda_oe_out,
  output logic busy_out
);
  import eeprom_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (WRITE_CYCLES <= PAGE_BYTES + 1) begin : g_bad_cycles
    $error("WRITE_CYCLES must exceed the page copy time");
  end

  localparam int WCW = $clog2(WRITE_CYCLES + 1);
  localparam logic [WCW-1:0] WAIT_LOAD = WCW'(WRITE_CYCLES - PAGE_BYTES - 1);
  localparam logic [WCW-1:0] WAIT_DONE = '0;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic scl_m, scl_s, sda_m, sda_s, sda_d, wp_m, wp_s;
  logic start_det, stop_det, link_hold, lrst_n;
  logic armed_m, armed_s, protected_hit;
  prog_state_t state;
  logic [PAGE_AW-1:0] idx;
  logic [WCW-1:0] wait_cnt;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [DATA_W-1:0] rd_data;
  logic busy_lm, busy_l;
  logic [3:0] cnt;
  logic [DATA_W-1:0] shift, tx;
  logic sda_rise, mack, in_ack, rd_first, wr_armed, blk_sel;
  logic start_tgl, start_seen;
  link_phase_t phase;
  logic [ADDR_W-1:0] ptr;
  logic [DATA_W-1:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask;
  logic start_cond, byte_end, ctrl_match, rd_load;

  // ----------------------------------------------------------------
  // System side: pin synchronisers and bus conditions
  // ----------------------------------------------------------------

  // Clock and data are idle high after reset so no false condition fires at release; protect resets low.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      wp_m <= 1'b0;
      wp_s <= 1'b0;
    end else if (ce_in) begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      wp_m <= wp_in;
      wp_s <= wp_m;
    end
  end

  // Data edges seen while the clock stays high.
  assign start_det = ce_in && scl_s && sda_d && !sda_s; // R06
  assign stop_det = ce_in && scl_s && !sda_d && sda_s; // R07

  // The link logic is held cleared from a stop until the next start, since the
  // link clock stands still on an idle bus and cannot clear itself.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_hold <= 1'b1;
    end else if (stop_det) begin
      link_hold <= 1'b1; // R07
    end else if (start_det) begin
      link_hold <= 1'b0; // R05
    end
  end

  assign lrst_n = rst_n_in & ~link_hold;

  // Write-pending level from the link side.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_m <= 1'b0;
      armed_s <= 1'b0;
    end else if (ce_in) begin
      armed_m <= wr_armed;
      armed_s <= armed_m;
    end
  end

  // ----------------------------------------------------------------
  // Programming sequencer
  // ----------------------------------------------------------------

  // Page, mask and pointer are quiet link registers here: no frame is acked
  // while busy, so the link side cannot change them during the copy.
  assign protected_hit = wp_s && ptr[ADDR_BLK_BIT]; // R03
  assign mem_we = ce_in && (state == PROG_COPY) && mask[idx]; // R17
  assign mem_wa = {ptr[ADDR_W-1:PAGE_AW], idx};

  // Copy one buffered byte per cycle, then wait out the rest of the write time.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= PROG_IDLE;
      idx <= '0;
      wait_cnt <= '0;
      busy_out <= 1'b0;
    end else if (ce_in) begin
      case (state)
        PROG_IDLE: begin
          if (stop_det && armed_s && !protected_hit) begin // R16 R21 R02
            state <= PROG_COPY;
            idx <= '0;
            busy_out <= 1'b1;
          end
        end
        PROG_COPY: begin
          idx <= idx + 4'h1;
          if (idx == IDX_LAST) begin
            state <= PROG_WAIT;
            wait_cnt <= WAIT_LOAD;
          end
        end
        PROG_WAIT: begin
          if (wait_cnt == WAIT_DONE) begin // R24
            state <= PROG_IDLE;
            busy_out <= 1'b0;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        default: begin
          state <= PROG_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain data pin: the level driven is always low.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_out_out <= 1'b0;
    end else begin
      sda_out_out <= 1'b0;
    end
  end

  page_store #(
    .AW(ADDR_W),
    .DW(DATA_W)
  ) u_store (
    .clk_in(clk_in),
    .ce_in(ce_in),
    .wr_en_in(mem_we),
    .wr_addr_in(mem_wa),
    .wr_data_in(page_buf[idx]),
    .rd_addr_in(ptr),
    .rd_data_out(rd_data)
  );

  // ----------------------------------------------------------------
  // Link side, clocked by the serial clock
  // ----------------------------------------------------------------

  // Busy level into the link domain; it has eight clocks of a control byte to settle.
  always_ff @(posedge scl_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_lm <= 1'b0;
      busy_l <= 1'b0;
    end else begin
      busy_lm <= busy_out;
      busy_l <= busy_lm;
    end
  end

  // Data is sampled on the rising clock edge; the master sets it up against
  // that edge, so the serial clock itself is the qualifier.
  always_ff @(posedge scl_in or negedge lrst_n) begin // R04
    if (!lrst_n) begin
      sda_rise <= 1'b0;
      cnt <= BIT_NONE;
      shift <= '0;
      mack <= 1'b0;
      start_seen <= 1'b0;
    end else begin
      sda_rise <= sda_in;
      if (start_seen != start_tgl) begin
        start_seen <= start_tgl;
        cnt <= BIT_FIRST;
        shift <= {shift[DATA_W-2:0], sda_in}; // R08
      end else if (cnt == ACK_SLOT) begin
        cnt <= BIT_NONE;
        mack <= ~sda_in; // R23
      end else begin
        cnt <= cnt + 4'h1;
        shift <= {shift[DATA_W-2:0], sda_in}; // R08
      end
    end
  end

  // A data level that differs at the falling edge from the rising edge moved
  // while the clock was high: a repeated start (a stop leaves via link_hold).
  assign start_cond = sda_rise && !sda_in; // R01 R06
  assign byte_end = !start_cond && (cnt == ACK_SLOT) && !in_ack;
  assign ctrl_match = (shift[CODE_HI:CODE_LO] == DEV_CODE) && !busy_l; // R12 R10 R20
  assign rd_load = !start_cond && (cnt == BIT_NONE) && in_ack && (phase == LINK_READ)
    && (rd_first || mack);

  // Framing and pin drive change only on the falling clock edge.
  always_ff @(negedge scl_in or negedge lrst_n) begin // R01
    if (!lrst_n) begin
      phase <= LINK_CTRL;
      in_ack <= 1'b0;
      sda_oe_out <= 1'b0;
      start_tgl <= 1'b0;
      tx <= '0;
      rd_first <= 1'b0;
      wr_armed <= 1'b0;
      blk_sel <= 1'b0;
    end else if (start_cond) begin
      start_tgl <= ~start_tgl;
      phase <= LINK_CTRL;
      in_ack <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (byte_end) begin
      in_ack <= 1'b1;
      sda_oe_out <= 1'b0;
      case (phase)
        LINK_CTRL: begin
          wr_armed <= 1'b0;
          if (ctrl_match) begin // R14
            sda_oe_out <= 1'b1; // R09
            blk_sel <= shift[CTRL_BLK_BIT]; // R12
            rd_first <= 1'b1;
            phase <= (shift[CTRL_RW_BIT] == CTRL_READ) ? LINK_READ : LINK_ADDR; // R13
          end else begin
            phase <= LINK_IGNORE; // R10
          end
        end
        LINK_ADDR: begin
          sda_oe_out <= 1'b1; // R15
          phase <= LINK_DATA;
        end
        LINK_DATA: begin
          sda_oe_out <= 1'b1; // R09
          wr_armed <= 1'b1;
        end
        default: begin
          sda_oe_out <= 1'b0;
        end
      endcase
    end else if ((cnt == BIT_NONE) && in_ack) begin
      in_ack <= 1'b0;
      sda_oe_out <= 1'b0;
      if (rd_load) begin // R23
        tx <= rd_data;
        sda_oe_out <= ~rd_data[DATA_W-1];
        rd_first <= 1'b0;
      end else if (phase == LINK_READ) begin
        phase <= LINK_IGNORE; // R11
      end
    end else if ((phase == LINK_READ) && (cnt != BIT_NONE) && (cnt != ACK_SLOT)) begin
      tx <= {tx[DATA_W-2:0], 1'b0};
      sda_oe_out <= ~tx[DATA_W-2];
    end
  end

  // Pointer and page mask survive the stop so the sequencer can commit them.
  always_ff @(negedge scl_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr <= '0;
      mask <= '0;
    end else if (byte_end && (phase == LINK_ADDR)) begin
      ptr <= {blk_sel, shift}; // R15
      mask <= '0;
    end else if (byte_end && (phase == LINK_DATA)) begin
      ptr[PAGE_AW-1:0] <= ptr[PAGE_AW-1:0] + 4'h1; // R18 R22
      mask[ptr[PAGE_AW-1:0]] <= 1'b1; // R17
    end else if (rd_load) begin
      ptr <= ptr + 9'h001; // R22
    end
  end

  // Later bytes overwrite earlier ones at the wrapped slot.
  always_ff @(negedge scl_in) begin
    if (byte_end && (phase == LINK_DATA)) begin
      page_buf[ptr[PAGE_AW-1:0]] <= shift; // R18
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  protect_skip_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R21
    (state == PROG_IDLE && stop_det && armed_s && protected_hit) |=> (state == PROG_IDLE)
  ) else $error("protected write started programming");

  commit_start_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R16
    (state == PROG_IDLE && stop_det && armed_s && !protected_hit) |=> busy_out
  ) else $error("stop after write did not start programming");

  upper_guard_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R03
    (state == PROG_IDLE && stop_det && wp_s && ptr[ADDR_BLK_BIT]) |=> !mem_we [*8]
  ) else $error("protected half was written");

  copy_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R17
    (ce_in && state == PROG_COPY && mask[idx]) |-> (mem_we && mem_wa[PAGE_AW-1:0] == idx)
  ) else $error("buffered byte not committed");

  write_end_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R24
    (ce_in && state == PROG_WAIT && wait_cnt == WAIT_DONE) |=> (!busy_out && state == PROG_IDLE)
  ) else $error("programming did not end on time");

  idle_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R05
    stop_det |=> (link_hold && !lrst_n)
  ) else $error("link not held after stop");

  busy_nack_a: assert property (@(negedge scl_in) disable iff (!lrst_n) // R10
    (byte_end && phase == LINK_CTRL && busy_l) |=> !sda_oe_out
  ) else $error("acknowledge given while programming");

  ctrl_ack_a: assert property (@(negedge scl_in) disable iff (!lrst_n) // R14
    (byte_end && phase == LINK_CTRL && shift[CODE_HI:CODE_LO] == DEV_CODE && !busy_l)
      |=> sda_oe_out
  ) else $error("matching control byte not acknowledged");

  page_wrap_a: assert property (@(negedge scl_in) disable iff (!rst_n_in) // R18
    (byte_end && phase == LINK_DATA)
      |=> (ptr[ADDR_W-1:PAGE_AW] == $past(ptr[ADDR_W-1:PAGE_AW]))
  ) else $error("page write left its page");

endmodule
`default_nettype wire

// [bench/i2c_master_model.sv]
// Behavioural two-wire bus master that drives the serial clock for the EEPROM slave.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
  parameter int Q = 15
) (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  // Idle bus: both lines high, clock stands still between frames.
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  // Start, also as a repeated start: data released before the clock rises, then pulled.
  task automatic start();
    if (!scl_out) begin
      #(2*Q);
      sda_pull_out = 1'b0;
      #(2*Q);
      scl_out = 1'b1;
    end
    #(3*Q);
    sda_pull_out = 1'b1;
    #(3*Q);
    scl_out = 1'b0;
  endtask

  // One clock pulse per bit; data moves mid-low so the slave's sync never sees a false edge.
  task automatic clock_bit(input logic b, output logic seen);
    #(2*Q);
    sda_pull_out = !b;
    #(2*Q);
    scl_out = 1'b1;
    #(3*Q);
    seen = sda_in;
    scl_out = 1'b0;
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], s);
    end
    clock_bit(1'b1, s);
    ack = !s;
  endtask

  // An acknowledge pulls the data line low; a last byte is answered by releasing it.
  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      d[i] = s;
    end
    clock_bit(!ack, s);
  endtask

  task automatic stop();
    #(2*Q);
    sda_pull_out = 1'b1;
    #(2*Q);
    scl_out = 1'b1;
    #(3*Q);
    sda_pull_out = 1'b0;
    #(3*Q);
  endtask
endmodule
`default_nettype wire

// [bench/i2c_eeprom_slave_write_path_tb.sv]
// Self-checking bench for the two-wire EEPROM slave write path.
`timescale 1ns/1ps
`default_nettype none
module i2c_eeprom_slave_write_path_tb;
  import eeprom_pkg::*;
  // ----------------------------------------------------------------
  // Set-up
  // ----------------------------------------------------------------
  // Long enough that acknowledge polling sees several refused bytes.
  localparam int WC = 400;
  localparam int LIMIT = 40000;
  logic clk_in, rst_n_in, ce_in, wp_in, scl, m_pull, sda, sda_out_out, sda_oe_out, busy_out;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int busy_run = 0;
  int busy_len = 0;

  // Open-drain wire with pull-up.
  assign sda = !(m_pull || (sda_oe_out && !sda_out_out));

  i2c_eeprom_slave #(.WRITE_CYCLES(WC)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(ce_in), .scl_in(scl), .sda_in(sda), .wp_in(wp_in), .sda_out_out(sda_out_out),
    .sda_oe_out(sda_oe_out), .busy_out(busy_out));
  i2c_master_model #(.Q(15)) m (.sda_in(sda), .scl_out(scl), .sda_pull_out(m_pull));

  // System clock.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Timeout and measurement of each busy pulse length.
  always @(negedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      complete_run();
    end
    if (busy_out === 1'b1) begin
      busy_run++;
    end else if (busy_run != 0) begin
      busy_len = busy_run;
      busy_run = 0;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Don't-care bits set to ones to show they are ignored.
  task automatic set_ptr(input logic [8:0] a);
    logic ack;
    m.start();
    m.write_byte({DEV_CODE, 2'b11, a[8], 1'b0}, ack);
    check({15'h0, ack}, 16'h1);
    m.write_byte(a[7:0], ack);
    check({15'h0, ack}, 16'h1);
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    logic ack;
    set_ptr(a);
    m.write_byte(d, ack);
    check({15'h0, ack}, 16'h1);
    m.stop();
  endtask

  task automatic read_seq(input logic [8:0] a, input logic [7:0] want[$]);
    logic ack;
    logic [7:0] d;
    set_ptr(a);
    m.start();
    m.write_byte({DEV_CODE, 2'b00, a[8], CTRL_READ}, ack);
    check({15'h0, ack}, 16'h1);
    foreach (want[i]) begin
      m.read_byte(i < want.size() - 1, d);
      check({8'h0, d}, {8'h0, want[i]});
    end
    // The drive enable moves on the falling edge that ends the task, so let it settle.
    #1;
    check({15'h0, sda_oe_out}, 16'h0);
    m.stop();
  endtask

  // Current-address read of one byte; the pointer stays where the last access left it.
  task automatic cur_read(input logic [7:0] exp);
    logic ack;
    logic [7:0] d;
    m.start();
    m.write_byte({DEV_CODE, 3'b000, CTRL_READ}, ack);
    check({15'h0, ack}, 16'h1);
    m.read_byte(1'b0, d);
    check({8'h0, d}, {8'h0, exp});
    m.stop();
  endtask

  // Polls with write control bytes until the device answers again.
  task automatic poll_ready();
    logic ack;
    int nacks;
    nacks = 0;
    ack = 1'b0;
    while (!ack && nacks < 30) begin
      m.start();
      m.write_byte(8'ha0, ack);
      m.stop();
      if (!ack) nacks++;
    end
    check(16'(nacks > 0), 16'h1);
    check({15'h0, busy_out}, 16'h0);
    check(16'(busy_len), 16'(WC));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_byte_write();
    wr(9'h012, 8'ha5);
    repeat (10) @(negedge clk_in);
    check({15'h0, busy_out}, 16'h1);
    poll_ready();
    read_seq(9'h012, '{8'ha5});
  endtask

  task automatic t_bad_code();
    logic ack;
    m.start();
    m.write_byte(8'hb0, ack);
    check({15'h0, ack}, 16'h0);
    m.write_byte(8'h55, ack);
    check({15'h0, ack}, 16'h0);
    m.stop();
  endtask

  // Eighteen bytes from slot 14: the last two wrap and overwrite the first two.
  task automatic t_page_wrap();
    logic ack;
    logic [7:0] want[$];
    for (int i = 0; i < 16; i++) want.push_back(8'h00);
    set_ptr(9'h11e);
    for (int i = 0; i < 18; i++) begin
      m.write_byte(8'(8'h40 + i), ack);
      check({15'h0, ack}, 16'h1);
      want[(14 + i) % 16] = 8'(8'h40 + i);
    end
    m.stop();
    poll_ready();
    // Eighteen increments of the low four bits leave the pointer at slot 0 of the page.
    cur_read(want[0]);
    read_seq(9'h110, want);
  endtask

  task automatic t_protect();
    wr(9'h1a0, 8'h3c);
    poll_ready();
    @(negedge clk_in);
    wp_in = 1'b1;
    repeat (4) @(negedge clk_in);
    wr(9'h1a0, 8'hc3);
    repeat (20) @(negedge clk_in);
    check({15'h0, busy_out}, 16'h0);
    read_seq(9'h1a0, '{8'h3c});
    wr(9'h0a0, 8'h77);
    poll_ready();
    read_seq(9'h0a0, '{8'h77});
    @(negedge clk_in);
    wp_in = 1'b0;
  endtask

  // Main sequence.
  initial begin
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    wp_in = 1'b0;
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_byte_write();
    t_bad_code();
    t_page_wrap();
    t_protect();
    complete_run();
  end
endmodule
`default_nettype wire
